//--- pkg/reset_src_pkg.sv
// Constants, encodings and timing for the pin and clock-loss reset sequencer.
// Assumes a 100 MHz system clock and a 1 us reference tick from a free-running oscillator.
package reset_src_pkg;

	localparam int CLK_PERIOD_NS = 10;

	// Reset stretch after release, in system clock cycles.
	localparam int STRETCH_CYCLES = 12;
	localparam logic [3:0] STRETCH_LAST = 4'(STRETCH_CYCLES - 1);

	// Clock-loss timeout as a time, and as a count of reference ticks.
	localparam int LOSS_TIMEOUT_US = 100;
	localparam int REF_TICK_NS = 1000;
	localparam int LOSS_TIMEOUT_TICKS_INT = LOSS_TIMEOUT_US * 1000 / REF_TICK_NS;
	localparam logic [6:0] LOSS_TIMEOUT_TICKS = 7'(LOSS_TIMEOUT_TICKS_INT);

	// Reset source register layout.
	localparam int PIN_FLAG_BIT = 0;
	localparam int LOSS_FLAG_BIT = 2;
	localparam logic [7:0] SRC_REG_RESET = 8'h00;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_PIN = 2'b01,
		ST_LOSS = 2'b10,
		ST_STRETCH = 2'b11
	} state_type;

	typedef enum logic [1:0] {
		CAUSE_NONE = 2'b00,
		CAUSE_PIN = 2'b01,
		CAUSE_LOSS = 2'b10
	} cause_type;

endpackage

//--- verilog/clock_loss_detector.sv
// Retriggerable one-shot that detects a stalled system clock.
// Assumes i_clk_valid marks each delivered clock edge and i_ref_tick is a 1 us tick from an independent oscillator.
module clock_loss_detector (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic i_clk_valid,
	input wire logic i_ref_tick,
	output logic o_fire
);

	typedef struct packed {
		logic [6:0] cnt;
		logic fire;
	} det_type;

	det_type r;
	det_type next_r;

	always_comb begin
		next_r = r;
		if (!i_enable || i_clk_valid) begin
			next_r.cnt = 7'h00;
			next_r.fire = 1'b0;
		end else if (i_ref_tick) begin
			if (r.cnt == reset_src_pkg::LOSS_TIMEOUT_TICKS) begin
				next_r.fire = 1'b1;
			end else begin
				next_r.cnt = 7'(r.cnt + 7'h01);
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_fire = r.fire;

	a_loss_timeout: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_enable && !i_clk_valid && i_ref_tick && r.cnt == reset_src_pkg::LOSS_TIMEOUT_TICKS) |=> o_fire)
		else $error("clock loss not flagged at timeout");

	a_loss_not_early: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		$rose(o_fire) |-> $past(r.cnt) == reset_src_pkg::LOSS_TIMEOUT_TICKS)
		else $error("clock loss flagged before timeout");

	a_clock_retrigger: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_valid |=> (r.cnt == 7'h00 && !o_fire))
		else $error("clock edge did not retrigger one-shot");

	a_disabled_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_enable |=> !o_fire)
		else $error("disabled detector fired");

endmodule // clock_loss_detector

//--- verilog/pin_and_clock_loss_reset.sv
// Reset sequencer for the external pin and the clock-loss detector, with the reset source register.
// Assumes the pin and software write strobe are synchronous to i_sys_clk; i_rst_n is the power-on reset.
module pin_and_clock_loss_reset (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_rst_pin_n,
	input wire logic i_clk_valid,
	input wire logic i_ref_tick,
	input wire logic i_src_wr,
	input wire logic [7:0] i_src_wdata,
	output logic o_rst_n,
	output logic [7:0] o_src_rdata
);

	typedef struct packed {
		reset_src_pkg::state_type state;
		logic [3:0] cnt;
		reset_src_pkg::cause_type cause;
		logic pin_flag;
		logic loss_flag;
	} seq_type;

	seq_type r;
	seq_type next_r;
	logic loss_fire;
	logic loss_enable;

	// The detector only runs while the part is out of reset and loss_flag is set, by a software write or by a clock-loss reset exit.
	assign loss_enable = (r.state == reset_src_pkg::ST_RUN) && r.loss_flag;

	clock_loss_detector u_det (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_enable(loss_enable),
		.i_clk_valid(i_clk_valid),
		.i_ref_tick(i_ref_tick),
		.o_fire(loss_fire)
	);

	always_comb begin
		next_r = r;
		case (r.state)
			reset_src_pkg::ST_RUN: begin
				if (!i_rst_pin_n) begin
					next_r.state = reset_src_pkg::ST_PIN;
				end else if (loss_fire && r.loss_flag) begin
					// The clock-loss reset stays internal; the pin is only ever an input.
					next_r.state = reset_src_pkg::ST_LOSS;
					next_r.cause = reset_src_pkg::CAUSE_LOSS;
				end else if (i_src_wr) begin
					next_r.loss_flag = i_src_wdata[reset_src_pkg::LOSS_FLAG_BIT];
				end
			end
			reset_src_pkg::ST_PIN: begin
				next_r.cause = reset_src_pkg::CAUSE_PIN;
				if (i_rst_pin_n) begin
					next_r.state = reset_src_pkg::ST_STRETCH;
					next_r.cnt = 4'h0;
				end
			end
			reset_src_pkg::ST_LOSS: begin
				if (!i_rst_pin_n) begin
					next_r.state = reset_src_pkg::ST_PIN;
				end else if (i_clk_valid) begin
					next_r.state = reset_src_pkg::ST_STRETCH;
					next_r.cnt = 4'h0;
				end
			end
			reset_src_pkg::ST_STRETCH: begin
				if (!i_rst_pin_n) begin
					next_r.state = reset_src_pkg::ST_PIN;
				end else if (r.cnt == reset_src_pkg::STRETCH_LAST) begin
					next_r.state = reset_src_pkg::ST_RUN;
					next_r.pin_flag = (r.cause == reset_src_pkg::CAUSE_PIN);
					next_r.loss_flag = (r.cause == reset_src_pkg::CAUSE_LOSS);
				end else begin
					next_r.cnt = 4'(r.cnt + 4'h1);
				end
			end
			default: begin
				next_r.state = reset_src_pkg::ST_STRETCH;
				next_r.cnt = 4'h0;
				next_r.cause = reset_src_pkg::CAUSE_NONE;
			end
		endcase
	end

	// Power-on reset enters the stretch with no recorded cause, so both flags come out clear.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			r.state <= reset_src_pkg::ST_STRETCH;
			r.cnt <= 4'h0;
			r.cause <= reset_src_pkg::CAUSE_NONE;
			r.pin_flag <= reset_src_pkg::SRC_REG_RESET[reset_src_pkg::PIN_FLAG_BIT];
			r.loss_flag <= reset_src_pkg::SRC_REG_RESET[reset_src_pkg::LOSS_FLAG_BIT];
		end else begin
			r <= next_r;
		end
	end

	assign o_rst_n = (r.state == reset_src_pkg::ST_RUN);

	always_comb begin
		o_src_rdata = 8'h00;
		o_src_rdata[reset_src_pkg::PIN_FLAG_BIT] = r.pin_flag;
		o_src_rdata[reset_src_pkg::LOSS_FLAG_BIT] = r.loss_flag;
	end

	sequence s_pin_release;
		r.state == reset_src_pkg::ST_PIN && i_rst_pin_n;
	endsequence

	sequence s_stretch_exit;
		r.state == reset_src_pkg::ST_STRETCH && r.cnt == reset_src_pkg::STRETCH_LAST && i_rst_pin_n;
	endsequence

	// Twelve consecutive cycles with the system reset held low.
	sequence s_twelve_low;
		(!o_rst_n) [*8] ##1 (!o_rst_n) [*4];
	endsequence

	// The clock has come back while the part sits in the clock-loss reset.
	sequence s_loss_resume;
		r.state == reset_src_pkg::ST_LOSS && i_rst_pin_n && i_clk_valid;
	endsequence

	a_pin_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_rst_pin_n |=> !o_rst_n)
		else $error("pin low but part not in reset");

	a_stretch_min: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_pin_release |=> (!o_rst_n) [*8] ##1 (!o_rst_n) [*4])
		else $error("reset released fewer than twelve cycles after pin");

	a_stretch_end: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_stretch_exit |=> o_rst_n)
		else $error("reset not released after stretch");

	a_pin_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(s_stretch_exit and r.cause == reset_src_pkg::CAUSE_PIN) |=>
			(o_src_rdata[reset_src_pkg::PIN_FLAG_BIT] && !o_src_rdata[reset_src_pkg::LOSS_FLAG_BIT]))
		else $error("pin reset flags wrong on exit");

	a_loss_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(s_stretch_exit and r.cause == reset_src_pkg::CAUSE_LOSS) |=>
			(o_src_rdata[reset_src_pkg::LOSS_FLAG_BIT] && !o_src_rdata[reset_src_pkg::PIN_FLAG_BIT]))
		else $error("clock loss reset flags wrong on exit");

	a_loss_enters: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_rst_n && i_rst_pin_n && loss_fire && r.loss_flag) |=> (!o_rst_n && r.state == reset_src_pkg::ST_LOSS))
		else $error("clock loss did not reset the part");

	a_loss_armed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_LOSS) |-> $past(r.loss_flag))
		else $error("clock loss reset while detector disarmed");

	a_arm_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_rst_n && i_rst_pin_n && !loss_fire && i_src_wr && i_src_wdata[reset_src_pkg::LOSS_FLAG_BIT]) |=>
			o_src_rdata[reset_src_pkg::LOSS_FLAG_BIT])
		else $error("write of one did not arm detector");

	a_other_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(s_stretch_exit and r.cause == reset_src_pkg::CAUSE_NONE) |=> (o_src_rdata == 8'h00))
		else $error("flags not clear after power-on reset");

	// Pin reset entry and restart, the stretch counter, and the clock-loss reset.
	a_pin_enters: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_rst_n && !i_rst_pin_n) |=> (r.state == reset_src_pkg::ST_PIN))
		else $error("pin low did not enter pin reset");

	a_pin_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_STRETCH && !i_rst_pin_n) |=> (r.state == reset_src_pkg::ST_PIN && !o_rst_n))
		else $error("pin low during stretch did not restart reset");

	a_pin_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_PIN) |=> (r.cause == reset_src_pkg::CAUSE_PIN))
		else $error("pin reset not recorded as cause");

	a_stretch_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_pin_release |=> (r.state == reset_src_pkg::ST_STRETCH && r.cnt == 4'h0))
		else $error("stretch did not start at zero");

	a_stretch_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_STRETCH && i_rst_pin_n && r.cnt != reset_src_pkg::STRETCH_LAST) |=>
			(r.state == reset_src_pkg::ST_STRETCH && r.cnt == 4'($past(r.cnt) + 4'h1)))
		else $error("stretch counter skipped a cycle");

	a_loss_stretch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_loss_resume |=> s_twelve_low)
		else $error("clock loss reset released fewer than twelve cycles after clock returned");

	a_loss_waits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_LOSS && i_rst_pin_n && !i_clk_valid) |=>
			(r.state == reset_src_pkg::ST_LOSS))
		else $error("clock loss reset left while clock still absent");

	a_loss_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_rst_n && i_rst_pin_n && loss_fire && r.loss_flag) |=> (r.cause == reset_src_pkg::CAUSE_LOSS))
		else $error("clock loss not recorded as cause");

	// Detector arming and the reset source flags.
	a_fire_armed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		loss_fire |-> $past(r.loss_flag))
		else $error("detector fired while disarmed");

	a_disarm_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_rst_n && i_rst_pin_n && !loss_fire && i_src_wr && !i_src_wdata[reset_src_pkg::LOSS_FLAG_BIT]) |=>
			!o_src_rdata[reset_src_pkg::LOSS_FLAG_BIT])
		else $error("write of zero did not disarm detector");

	a_loss_rdata: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_LOSS) |-> o_src_rdata[reset_src_pkg::LOSS_FLAG_BIT])
		else $error("clock loss flag low during clock loss reset");

	a_pin_flag_run: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_rst_n && i_rst_pin_n) |=> $stable(o_src_rdata[reset_src_pkg::PIN_FLAG_BIT]))
		else $error("pin flag changed while running");

	// Flags change only at reset exit, by a write while running, or when the power-on reset clears them.
	a_reset_flags_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_PIN || r.state == reset_src_pkg::ST_LOSS) |=> $stable(o_src_rdata))
		else $error("flags changed while held in reset");

	a_stretch_refuse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(r.state == reset_src_pkg::ST_STRETCH && r.cnt != reset_src_pkg::STRETCH_LAST) |=> $stable(o_src_rdata))
		else $error("flags changed during stretch");

endmodule // pin_and_clock_loss_reset

//--- tb/host_side_model.sv
// Far-side model: the free-running 1 us reference tick and the clock-presence flag.
// Assumes a 100 MHz i_sys_clk; i_stall stands for the system clock going away.
module host_side_model (
	input wire logic i_sys_clk,
	input wire logic i_stall,
	output logic o_clk_valid = 1'b1,
	output logic o_ref_tick = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] div = 7'h00;
	// One tick every 100 cycles, whether or not the system clock is present.
	always @(posedge i_sys_clk) begin
		div <= (div == 7'h63) ? 7'h00 : div + 7'h01;
		o_ref_tick <= (div == 7'h63);
		o_clk_valid <= !i_stall;
	end
endmodule // host_side_model

//--- tb/pin_and_clock_loss_reset_tb.sv
// Self-checking bench for the pin and clock-loss reset sequencer.
// Assumes the far-side model supplies the reference tick and the clock-presence flag.
module pin_and_clock_loss_reset_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_rst_pin_n = 1'b1, i_src_wr = 1'b0, stall = 1'b0;
	logic [7:0] i_src_wdata = 8'h00;
	logic clk_valid, ref_tick, o_rst_n;
	logic [7:0] o_src_rdata;
	int mismatches = 0;
	int total_checks = 0;
	int n;
	always #5 i_sys_clk = ~i_sys_clk;
	host_side_model far (.i_sys_clk(i_sys_clk), .i_stall(stall), .o_clk_valid(clk_valid), .o_ref_tick(ref_tick));
	pin_and_clock_loss_reset dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_rst_pin_n(i_rst_pin_n),
		.i_clk_valid(clk_valid), .i_ref_tick(ref_tick), .i_src_wr(i_src_wr), .i_src_wdata(i_src_wdata),
		.o_rst_n(o_rst_n), .o_src_rdata(o_src_rdata));
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: register %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_true(input logic ok);
		total_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: reset output timing", $time);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge i_sys_clk);
	endtask
	// Counts clock edges up to and including the one that brings the reset output to lvl.
	task automatic wait_rst(input logic lvl, input int bound, output int cnt);
		cnt = 0;
		while (1) begin
			step(1);
			#1;
			cnt++;
			if (o_rst_n === lvl) break;
			if (cnt >= bound) begin
				mismatches++;
				$display("wrong value at %0t: reset output wait ran out", $time);
				conclude();
			end
		end
	endtask
	task automatic t_power_on();
		if (i_rst_n === 1'b1) step(1);
		i_rst_n <= 1'b0;
		step(16);
		i_rst_n <= 1'b1;
		#1;
		cmp_true(o_rst_n === 1'b0);
		cmp8(o_src_rdata, 8'h00);
		wait_rst(1'b1, 100, n);
		cmp_true(n >= 12 && n <= 16);
		cmp8(o_src_rdata, 8'h00);
	endtask
	task automatic t_write(input logic [7:0] data, input logic [7:0] exp);
		step(1);
		i_src_wr <= 1'b1;
		i_src_wdata <= data;
		step(1);
		i_src_wr <= 1'b0;
		#1;
		cmp8(o_src_rdata, exp);
	endtask
	// Pin pulled low again part way through the stretch: the whole stretch restarts.
	task automatic t_pin_restart();
		step(1);
		i_rst_pin_n <= 1'b0;
		step(2);
		i_rst_pin_n <= 1'b1;
		step(5);
		i_rst_pin_n <= 1'b0;
		step(2);
		i_rst_pin_n <= 1'b1;
		wait_rst(1'b1, 100, n);
		cmp_true(n >= 12 && n <= 16);
		cmp8(o_src_rdata, 8'h01);
	endtask
	task automatic t_pin_reset();
		step(1);
		i_rst_pin_n <= 1'b0;
		step(4);
		#1;
		cmp_true(o_rst_n === 1'b0);
		step(1);
		i_rst_pin_n <= 1'b1;
		wait_rst(1'b1, 100, n);
		cmp_true(n >= 12 && n <= 16);
		cmp8(o_src_rdata, 8'h01);
	endtask
	task automatic t_disarmed();
		logic ok;
		ok = 1'b1;
		step(1);
		stall <= 1'b1;
		repeat (11000) begin
			step(1);
			#1;
			if (o_rst_n !== 1'b1) ok = 1'b0;
		end
		cmp_true(ok);
		step(1);
		stall <= 1'b0;
		step(2);
	endtask
	task automatic t_clock_loss();
		t_write(8'h04, 8'h05);
		step(1);
		stall <= 1'b1;
		wait_rst(1'b0, 11000, n);
		cmp_true(n >= 10000 && n <= 10300);
		step(20);
		stall <= 1'b0;
		wait_rst(1'b1, 100, n);
		cmp_true(n >= 12);
		cmp8(o_src_rdata, 8'h04);
	endtask
	initial begin
		t_power_on();
		t_pin_reset();
		t_disarmed();
		t_clock_loss();
		t_write(8'h00, 8'h00);
		t_write(8'h04, 8'h04);
		t_pin_reset();
		t_pin_restart();
		t_write(8'h04, 8'h05);
		t_power_on();
		t_write(8'h05, 8'h04);
		conclude();
	end
endmodule // pin_and_clock_loss_reset_tb
